/* File: hdl/nor_bus_cycle.sv */
// one asynchronous flash read or write cycle on the pins
`timescale 1ns/1ps
module nor_bus_cycle (
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    input  wire logic                     START,
    input  wire logic                     WRITE,
    input  wire logic [nor_host_pkg::AW-1:0] ADDR,
    input  wire logic [nor_host_pkg::DW-1:0] WDATA,
    input  wire logic [nor_host_pkg::DW-1:0] DQ_I,
    output logic                          IDLE,
    output logic                          DONE,
    output logic [nor_host_pkg::DW-1:0]   RDATA,
    output nor_host_pkg::pins_t           PINS
);
    import nor_host_pkg::*;

    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_t;

    cyc_t          state_q;
    logic [2:0]    cnt_q;
    logic          wr_q;
    logic [DW-1:0] dq_s1_q;
    logic [DW-1:0] dq_s2_q;
    logic [DW-1:0] rdata_q;
    pins_t         pins_q;

    wire [2:0] strobe_len = wr_q ? 3'(WP_CYC) : 3'(RD_CYC);
    wire       strobe_end = (state_q == C_STROBE) && (cnt_q == strobe_len - 3'h1);

    assign IDLE  = (state_q == C_IDLE);
    assign DONE  = (state_q == C_HOLD);
    assign RDATA = rdata_q;
    assign PINS  = pins_q;

    always_ff @(posedge CLK)
    begin
        dq_s1_q <= DQ_I;
        dq_s2_q <= dq_s1_q;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_q <= C_IDLE;
            cnt_q   <= 3'h0;
            wr_q    <= 1'b0;
            rdata_q <= '0;
            pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                         addr: '0, dq_o: '0};
        end
        else
        begin
            unique case (state_q)
                C_IDLE:
                    if (START)
                    begin
                        state_q        <= C_SETUP;
                        wr_q           <= WRITE;
                        pins_q.ce_n    <= 1'b0;
                        pins_q.addr    <= ADDR;
                        pins_q.dq_o    <= WDATA;
                        pins_q.dq_oe_n <= ~WRITE;
                    end
                C_SETUP:
                begin
                    state_q     <= C_STROBE;
                    cnt_q       <= 3'h0;
                    pins_q.we_n <= ~wr_q;
                    pins_q.oe_n <= wr_q;
                end
                C_STROBE:
                begin
                    cnt_q <= cnt_q + 3'h1;
                    if (strobe_end)
                    begin
                        state_q     <= C_HOLD;
                        pins_q.we_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        if (!wr_q)
                            rdata_q <= dq_s2_q;
                    end
                end
                C_HOLD:
                begin
                    state_q        <= C_IDLE;
                    pins_q.ce_n    <= 1'b1;
                    pins_q.dq_oe_n <= 1'b1;
                end
            endcase
        end
    end

    strobe_ce_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (!PINS.we_n || !PINS.oe_n) |-> !PINS.ce_n)
        else $error("strobe active without chip select");
    bus_contend_a: assert property (@(posedge CLK) disable iff (!RSTN)
        !PINS.oe_n |-> PINS.dq_oe_n)
        else $error("host drives data while output enable low");
    write_width_a: assert property (@(posedge CLK) disable iff (!RSTN)
        $fell(PINS.we_n) |=> PINS.we_n)
        else $error("write strobe width wrong");
endmodule

/* File: hdl/nor_host_ctrl.sv */
// host side command sequencer for an asynchronous nor flash
`timescale 1ns/1ps
module nor_host_ctrl (
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    input  wire logic                     CMD_VALID,
    output logic                          CMD_READY,
    input  nor_host_pkg::req_t            CMD_REQ,
    output logic                          RSP_VALID,
    output logic                          RSP_REFUSED,
    output logic [nor_host_pkg::DW-1:0]   RSP_DATA,
    output nor_host_pkg::mode_t           MODE,
    output logic                          ABORT_WAIT,
    output nor_host_pkg::pins_t           FLASH,
    input  wire logic [nor_host_pkg::DW-1:0] DQ_I,
    input  wire logic                     READY_BUSY_OUT
);
    import nor_host_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_BUS, S_WAIT} st_t;

    st_t           state_q;
    req_t          req_q;
    logic [2:0]    step_q;
    mode_t         mode_q;
    logic          rsp_valid_q;
    logic          rsp_ref_q;
    logic [DW-1:0] rsp_data_q;
    logic          buf_open_q;
    logic [5:0]    buf_left_q;
    logic          enh_open_q;
    logic [8:0]    enh_idx_q;
    logic [AW-1:0] base_q;
    logic          erase_open_q;
    logic [7:0]    wait_q;
    logic          rb_s1_q;
    logic          rb_s2_q;
    logic [AW-1:0] seq_addr;
    logic [DW-1:0] seq_data;
    logic          seq_wr;
    logic          seq_last;
    logic          eng_idle;
    logic          eng_done;
    logic [DW-1:0] eng_rdata;

    wire accept   = CMD_VALID && CMD_READY;
    wire unlock   = (req_q.op inside {OP_RESET3, OP_AUTOSEL, OP_BUF_START, OP_ENH_START,
                                      OP_ERASE}) && (step_q < 3'h2);
    wire [5:0] n_words = CMD_REQ.data[5:0];
    wire bad_count = (n_words == 6'h0) || (n_words > BUF_MAX) || (|CMD_REQ.data[15:6]);
    wire refuse =
        ((CMD_REQ.op == OP_QUERY) && !(mode_q inside {MODE_ARRAY, MODE_ID})) ||
        ((CMD_REQ.op == OP_AUTOSEL) && !rb_s2_q) ||
        ((CMD_REQ.op == OP_BUF_START) && bad_count) ||
        ((CMD_REQ.op == OP_BUF_DATA) && !(buf_open_q && buf_left_q != 6'h0)) ||
        ((CMD_REQ.op == OP_ENH_DATA) && !(enh_open_q && enh_idx_q != ENH_WORDS)) ||
        ((CMD_REQ.op == OP_CONFIRM) && !(buf_open_q ||
                                         (enh_open_q && enh_idx_q == ENH_WORDS))) ||
        ((CMD_REQ.op == OP_ERASE_MORE) && !erase_open_q);
    wire is_reset  = (req_q.op inside {OP_RESET1, OP_RESET3});
    wire seq_end   = eng_done && seq_last;
    wire [AW-1:0] sig_addr = {req_q.addr[AW-1:SIG_A7+1], 3'h0, req_q.addr[SIG_A5-1:SIG_A3+1],
                              {3{req_q.data[1]}}, req_q.data[0]};

    assign CMD_READY   = (state_q == S_IDLE);
    assign RSP_VALID   = rsp_valid_q;
    assign RSP_REFUSED = rsp_ref_q;
    assign RSP_DATA    = rsp_data_q;
    assign MODE        = mode_q;
    assign ABORT_WAIT  = (state_q == S_WAIT);

    always_comb
    begin
        seq_addr = req_q.addr;
        seq_data = req_q.data;
        seq_wr   = 1'b1;
        seq_last = 1'b1;
        if (unlock)
        begin
            seq_addr = (step_q == 3'h0) ? ADDR_UNLOCK1 : ADDR_UNLOCK2;
            seq_data = (step_q == 3'h0) ? DATA_UNLOCK1 : DATA_UNLOCK2;
            seq_last = 1'b0;
        end
        else
        begin
            unique case (req_q.op)
                OP_READ:       seq_wr = 1'b0;
                OP_SIG:
                begin
                    seq_wr   = 1'b0;
                    seq_addr = sig_addr;
                end
                OP_RESET1, OP_RESET3:
                begin
                    seq_addr = ADDR_UNLOCK1;
                    seq_data = CMD_RESET;
                end
                OP_QUERY:
                begin
                    seq_addr = ADDR_QUERY;
                    seq_data = CMD_QUERY;
                end
                OP_AUTOSEL:
                begin
                    seq_addr = ADDR_UNLOCK1;
                    seq_data = CMD_AUTOSEL;
                end
                OP_BUF_START:
                begin
                    seq_data = (step_q == 3'h2) ? CMD_BUF_LOAD
                                                : {10'h0, req_q.data[5:0] - 6'h1};
                    seq_last = (step_q == 3'h3);
                end
                OP_BUF_DATA:   seq_addr = {base_q[AW-1:PAGE_LSB], req_q.addr[PAGE_LSB-1:0]};
                OP_ENH_START:
                begin
                    seq_addr = ADDR_UNLOCK1;
                    seq_data = CMD_ENH_LOAD;
                end
                OP_ENH_DATA:   seq_addr = {base_q[AW-1:ENH_LSB], enh_idx_q[7:0]};
                OP_CONFIRM:
                begin
                    seq_addr = base_q;
                    seq_data = CMD_CONFIRM;
                end
                OP_ERASE:
                begin
                    seq_addr = (step_q == 3'h4) ? ADDR_UNLOCK2
                             : (step_q == 3'h5) ? req_q.addr : ADDR_UNLOCK1;
                    seq_data = (step_q == 3'h2) ? CMD_ERASE
                             : (step_q == 3'h3) ? DATA_UNLOCK1
                             : (step_q == 3'h4) ? DATA_UNLOCK2 : CMD_BLK_ERS;
                    seq_last = (step_q == 3'h5);
                end
                OP_ERASE_MORE: seq_data = CMD_BLK_ERS;
                default:       seq_wr = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        rb_s1_q <= READY_BUSY_OUT;
        rb_s2_q <= rb_s1_q;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_q     <= S_IDLE;
            req_q       <= '{op: OP_READ, addr: '0, data: '0};
            step_q      <= 3'h0;
            wait_q      <= 8'h0;
            rsp_valid_q <= 1'b0;
            rsp_ref_q   <= 1'b0;
            rsp_data_q  <= '0;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            rsp_ref_q   <= 1'b0;
            unique case (state_q)
                S_IDLE:
                    if (accept)
                    begin
                        req_q  <= CMD_REQ;
                        step_q <= 3'h0;
                        if (refuse)
                        begin
                            rsp_valid_q <= 1'b1;
                            rsp_ref_q   <= 1'b1;
                        end
                        else
                            state_q <= S_BUS;
                    end
                S_BUS:
                    if (eng_done)
                    begin
                        step_q <= step_q + 3'h1;
                        if (seq_last)
                        begin
                            rsp_data_q <= seq_wr ? '0 : eng_rdata;
                            if (is_reset && erase_open_q)
                            begin
                                state_q <= S_WAIT;
                                wait_q  <= 8'(ABORT_CYC - 1);
                            end
                            else
                            begin
                                state_q     <= S_IDLE;
                                rsp_valid_q <= 1'b1;
                            end
                        end
                    end
                S_WAIT:
                begin
                    wait_q <= wait_q - 8'h1;
                    if (wait_q == 8'h0)
                    begin
                        state_q     <= S_IDLE;
                        rsp_valid_q <= 1'b1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            mode_q       <= MODE_ARRAY;
            buf_open_q   <= 1'b0;
            buf_left_q   <= 6'h0;
            enh_open_q   <= 1'b0;
            enh_idx_q    <= 9'h0;
            base_q       <= '0;
            erase_open_q <= 1'b0;
        end
        else if (seq_end)
        begin
            erase_open_q <= (req_q.op inside {OP_ERASE, OP_ERASE_MORE});
            unique case (req_q.op)
                OP_RESET1, OP_RESET3:
                begin
                    buf_open_q <= 1'b0;
                    enh_open_q <= 1'b0;
                    mode_q     <= (mode_q == MODE_QUERY_I) ? MODE_ID : MODE_ARRAY;
                end
                OP_QUERY:      mode_q <= (mode_q == MODE_ID) ? MODE_QUERY_I : MODE_QUERY_A;
                OP_AUTOSEL:    mode_q <= MODE_ID;
                OP_BUF_START:
                begin
                    buf_open_q <= 1'b1;
                    buf_left_q <= req_q.data[5:0];
                    base_q     <= req_q.addr;
                end
                OP_BUF_DATA:   buf_left_q <= buf_left_q - 6'h1;
                OP_ENH_START:
                begin
                    enh_open_q <= 1'b1;
                    enh_idx_q  <= 9'h0;
                    base_q     <= req_q.addr;
                end
                OP_ENH_DATA:   enh_idx_q <= enh_idx_q + 9'h1;
                OP_CONFIRM:
                begin
                    buf_open_q <= 1'b0;
                    enh_open_q <= 1'b0;
                end
                default:       mode_q <= mode_q;
            endcase
        end
    end

    nor_bus_cycle u_cycle (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .START ((state_q == S_BUS) && eng_idle),
        .WRITE (seq_wr),
        .ADDR  (seq_addr),
        .WDATA (seq_data),
        .DQ_I  (DQ_I),
        .IDLE  (eng_idle),
        .DONE  (eng_done),
        .RDATA (eng_rdata),
        .PINS  (FLASH)
    );

    query_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (accept && CMD_REQ.op == OP_QUERY && mode_q inside {MODE_QUERY_A, MODE_QUERY_I})
        |=> RSP_VALID && RSP_REFUSED)
        else $error("query command not refused in query mode");
    busy_autosel_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (accept && CMD_REQ.op == OP_AUTOSEL && !rb_s2_q) |=> state_q == S_IDLE)
        else $error("identification sent while busy");
    query_exit_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (seq_end && is_reset && mode_q == MODE_QUERY_I) |=> mode_q == MODE_ID)
        else $error("reset from query did not return to identification");
    abort_wait_a: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(ABORT_WAIT) |-> ##199 (ABORT_WAIT ##1 !ABORT_WAIT))
        else $error("abort wait length wrong");
    count_minus_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == S_BUS && req_q.op == OP_BUF_START && step_q == 3'h3 && !FLASH.we_n)
        |-> FLASH.dq_o == {10'h0, req_q.data[5:0] - 6'h1})
        else $error("buffer count not units minus one");
    page_fixed_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == S_BUS && req_q.op == OP_BUF_DATA)
        |-> seq_addr[AW-1:PAGE_LSB] == base_q[AW-1:PAGE_LSB])
        else $error("buffer upper address moved");
    sig_addr_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == S_BUS && req_q.op == OP_SIG) |-> seq_addr[SIG_A7:SIG_A5] == 3'h0 && !seq_wr)
        else $error("signature read address bits 7-5 not low");
    reset_seq_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (seq_end && req_q.op == OP_RESET3) |-> step_q == 3'h2 && seq_data == CMD_RESET)
        else $error("three-write reset sequence malformed");
endmodule

/* File: hdl/nor_host_pkg.sv */
// constants, codes and carrier types for the nor flash host controller
package nor_host_pkg;
    localparam int          CLK_NS       = 50;
    localparam int          T_WP_NS      = 50;
    localparam int          T_ACC_NS     = 80;
    localparam int          T_ABORT_NS   = 10000;
    localparam int          SYNC_CYC     = 2;
    localparam int          WP_CYC       = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RD_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
    localparam int          ABORT_CYC    = (T_ABORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          AW           = 23;
    localparam int          DW           = 16;
    localparam logic [22:0] ADDR_UNLOCK1 = 23'h000555;
    localparam logic [22:0] ADDR_UNLOCK2 = 23'h0002AA;
    localparam logic [22:0] ADDR_QUERY   = 23'h000055;
    localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_RESET    = 16'h00F0;
    localparam logic [15:0] CMD_QUERY    = 16'h0098;
    localparam logic [15:0] CMD_AUTOSEL  = 16'h0090;
    localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
    localparam logic [15:0] CMD_ENH_LOAD = 16'h0033;
    localparam logic [15:0] CMD_CONFIRM  = 16'h0029;
    localparam logic [15:0] CMD_ERASE    = 16'h0080;
    localparam logic [15:0] CMD_BLK_ERS  = 16'h0030;
    localparam logic [5:0]  BUF_MAX      = 6'h20;
    localparam logic [8:0]  ENH_WORDS    = 9'h100;
    localparam int          SIG_A1       = 1;
    localparam int          SIG_A3       = 3;
    localparam int          SIG_A5       = 5;
    localparam int          SIG_A7       = 7;
    localparam int          PAGE_LSB     = 5;
    localparam int          ENH_LSB      = 8;

    typedef enum logic [3:0] {
        OP_READ, OP_RESET1, OP_RESET3, OP_QUERY, OP_AUTOSEL, OP_SIG,
        OP_BUF_START, OP_BUF_DATA, OP_ENH_START, OP_ENH_DATA, OP_CONFIRM,
        OP_ERASE, OP_ERASE_MORE
    } op_t;

    typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_QUERY_A, MODE_QUERY_I} mode_t;

    typedef struct packed {
        op_t           op;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } req_t;

    typedef struct packed {
        logic          ce_n;
        logic          oe_n;
        logic          we_n;
        logic          dq_oe_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_o;
    } pins_t;
endpackage

/* File: test/nor_flash_model.sv */
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module nor_flash_model
    import nor_host_pkg::*;
#(
    parameter logic [15:0] MFR_CODE = 16'h1A2B, // arbitrary value
    parameter logic [15:0] DEV1     = 16'h3C4D, // arbitrary value
    parameter logic [15:0] DEV2     = 16'h5E6F, // arbitrary value
    parameter logic [15:0] DEV3     = 16'h7A8B  // arbitrary value
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire pins_t       pins,
    input  wire logic        ready_busy_out,
    output logic [15:0]      dq
);
    logic [1:0]  cyc_q;
    mode_t       mode_q;
    logic [15:0] junk_q = 16'h5A5A;
    wire         we_n = pins.we_n;
    wire         rd   = !pins.ce_n && !pins.oe_n;
    wire  [3:0]  sa   = pins.addr[3:0];
    wire  [15:0] sig_val = (pins.addr[7:5] != 3'h0) ? 16'h0BAD : (sa == 4'h0) ? MFR_CODE
                         : (sa == 4'h1) ? DEV1 : (sa == 4'hE) ? DEV2 : (sa == 4'hF) ? DEV3
                         : 16'h0BAD;
    wire  [15:0] rd_val  = mode_q[1] ? (16'h5100 | {8'h00, pins.addr[7:0]})
                         : (mode_q == MODE_ID) ? sig_val : (pins.addr[15:0] ^ 16'hA5A5);
    // released bus shows a pattern that settles at 16'hFFFF after five clocks
    assign dq = rd ? rd_val : junk_q;
    always @(posedge clk)
        junk_q <= ~junk_q ^ {junk_q[14:0], junk_q[15]};
    // write decoder on the strobe's rising edge
    always @(posedge we_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_ARRAY;
            cyc_q  <= 2'd0;
        end
        else if (!pins.ce_n)
        begin
            if (pins.dq_o == CMD_RESET)
            begin
                mode_q <= (mode_q == MODE_QUERY_I) ? MODE_ID : MODE_ARRAY;
                cyc_q  <= 2'd0;
            end
            else if (pins.dq_o == CMD_QUERY && mode_q inside {MODE_ARRAY, MODE_ID})
                mode_q <= (mode_q == MODE_ID) ? MODE_QUERY_I : MODE_QUERY_A;
            else if (cyc_q == 2'd0 && pins.addr == ADDR_UNLOCK1 && pins.dq_o == DATA_UNLOCK1)
                cyc_q <= 2'd1;
            else if (cyc_q == 2'd1 && pins.addr == ADDR_UNLOCK2 && pins.dq_o == DATA_UNLOCK2)
                cyc_q <= 2'd2;
            else
            begin
                if (cyc_q == 2'd2 && pins.dq_o == CMD_AUTOSEL && ready_busy_out)
                    mode_q <= MODE_ID;
                cyc_q <= 2'd0;
            end
        end
    end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the nor flash host controller
`timescale 1ns/1ps
module testbench;
    import nor_host_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        cmd_valid = 0;
    logic        busy_n = 1;
    req_t        req = '0;
    pins_t       pins;
    mode_t       mode;
    logic [15:0] dq, rsp_data, rdata;
    logic        cmd_ready, rsp_valid, rsp_refused, abort_wait, aw_seen;
    int          fails = 0, n_tests = 0, cyc = 0, wait_cyc = 0;
    logic [15:0] sig [4] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7A8B};

    always #25 clk = ~clk;

    nor_host_ctrl i_dut (.CLK(clk), .RSTN(rst_n), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_REQ(req), .RSP_VALID(rsp_valid), .RSP_REFUSED(rsp_refused), .RSP_DATA(rsp_data),
        .MODE(mode), .ABORT_WAIT(abort_wait), .FLASH(pins), .DQ_I(dq),
        .READY_BUSY_OUT(busy_n));
    nor_flash_model #(.MFR_CODE(16'h1A2B), .DEV1(16'h3C4D), .DEV2(16'h5E6F), .DEV3(16'h7A8B))
        i_flash (.clk(clk), .rst_n(rst_n), .pins(pins), .ready_busy_out(busy_n), .dq(dq));

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one request, held until taken, then wait for the answer
    task op(input op_t o, input logic [22:0] a, input logic [15:0] d, input logic ref_x);
        @(negedge clk);
        req = '{o, a, d};
        cmd_valid = 1;
        for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++)
            @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
        aw_seen = 0;
        for (wait_cyc = 0; wait_cyc < 400 && rsp_valid !== 1'b1; wait_cyc++)
        begin
            @(negedge clk);
            aw_seen |= abort_wait;
        end
        rdata = rsp_data;
        chk({15'h0, rsp_valid}, 16'h1);
        chk({15'h0, rsp_refused}, {15'h0, ref_x});
    endtask

    task t_start;
        chk({14'h0, mode}, {14'h0, MODE_ARRAY});
        op(OP_READ, 23'h001234, 16'h0, 0);
        chk(rdata, 16'h1234 ^ 16'hA5A5);
    endtask

    task t_ident;
        busy_n = 0;
        repeat (3) @(negedge clk);
        op(OP_AUTOSEL, 23'h0, 16'h0, 1);
        chk({14'h0, mode}, {14'h0, MODE_ARRAY});
        busy_n = 1;
        repeat (3) @(negedge clk);
        op(OP_AUTOSEL, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_ID});
        for (int k = 0; k < 4; k++)
        begin
            op(OP_SIG, 23'h0400E0, 16'(k), 0);
            chk(rdata, sig[k]);
        end
        op(OP_QUERY, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_QUERY_I});
        op(OP_READ, 23'h000010, 16'h0, 0);
        chk(rdata, 16'h5110);
        op(OP_RESET1, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_ID});
        op(OP_SIG, 23'h0, 16'h0, 0);
        chk(rdata, sig[0]);
        op(OP_RESET3, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_ARRAY});
        op(OP_READ, 23'h000077, 16'h0, 0);
        chk(rdata, 16'h0077 ^ 16'hA5A5);
    endtask

    task t_query;
        op(OP_QUERY, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_QUERY_A});
        op(OP_QUERY, 23'h0, 16'h0, 1);
        op(OP_RESET1, 23'h0, 16'h0, 0);
        chk({14'h0, mode}, {14'h0, MODE_ARRAY});
    endtask

    task t_buffer;
        op(OP_BUF_DATA, 23'h040000, 16'h1234, 1);
        op(OP_BUF_START, 23'h040000, 16'h0000, 1);
        op(OP_BUF_START, 23'h040000, 16'h0021, 1);
        op(OP_BUF_START, 23'h040000, 16'h0020, 0);
        for (int i = 0; i < 32; i++)
            op(OP_BUF_DATA, 23'h040000 + 23'(i), 16'h1234, 0);
        op(OP_BUF_DATA, 23'h040000, 16'h1234, 1);
        op(OP_CONFIRM, 23'h040000, 16'h0, 0);
        op(OP_BUF_START, 23'h040000, 16'h0002, 0);
        op(OP_RESET1, 23'h0, 16'h0, 0);
        op(OP_BUF_DATA, 23'h040000, 16'h1234, 1);
        op(OP_CONFIRM, 23'h040000, 16'h0, 1);
    endtask

    task t_enh;
        op(OP_ENH_START, 23'h080000, 16'h1234, 0);
        op(OP_CONFIRM, 23'h080000, 16'h0, 1);
        for (int i = 0; i < 256; i++)
            op(OP_ENH_DATA, 23'h080000, 16'h1234, 0);
        op(OP_ENH_DATA, 23'h080000, 16'h1234, 1);
        op(OP_CONFIRM, 23'h080000, 16'h0, 0);
    endtask

    task t_erase;
        op(OP_ERASE_MORE, 23'h030000, 16'h0, 1);
        op(OP_ERASE, 23'h020000, 16'h0, 0);
        op(OP_ERASE_MORE, 23'h030000, 16'h0, 0);
        op(OP_RESET1, 23'h0, 16'h0, 0);
        chk({15'h0, aw_seen}, 16'h1);
        chk({15'h0, wait_cyc >= ABORT_CYC}, 16'h1);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        t_start();
        t_ident();
        t_query();
        t_buffer();
        t_enh();
        t_erase();
        tally_and_finish();
    end
endmodule
